// File: branch_call_return_decode.sv
// Control-flow instruction decode and execute: jumps, calls, system calls, returns, interrupt gate
//
// Function
// (RL1) Direct jump loads pc bits 10..0 from address; opcode 01100..01111 picks page 0..3.
// (RL2) Indirect jump copies address register to pc; indirect call also pushes pc first.
// (RL3) Direct call pushes pc, clears pc bit 11, loads bits 10..0 from address.
// (RL4) System call pushes pc, sets flag, builds entry address from upper and lower fields.
// (RL5) Plain return pops pc from stack top and increments stack pointer.
// (RL6) Return-with-skip pops pc and skips the instruction at the return address.
// (RL7) Return from interrupt pops pc and restores interrupt context from saved copy.
// (RL8) Interrupt unmask sets the global gate; interrupt mask clears it.
`timescale 1ns/100ps
module branch_call_return_decode (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [ctrl_flow_pkg::PC_W-1:0] address_register,
    input wire logic [ctrl_flow_pkg::PC_W-1:0] stack_top,
    input wire logic [ctrl_flow_pkg::CTX_W-1:0] interrupt_context_copy,
    output logic [ctrl_flow_pkg::PC_W-1:0] pc,
    output logic [ctrl_flow_pkg::SP_W-1:0] sp,
    output logic push_strobe,
    output logic [ctrl_flow_pkg::PC_W-1:0] push_data,
    output logic skip_next,
    output logic system_call_flag,
    output logic [ctrl_flow_pkg::CTX_W-1:0] interrupt_context_reg,
    output logic global_irq_gate
);
    // ****************************************
    // Decode
    // ****************************************
    logic [4:0] op;
    logic [2:0] mid;
    logic [3:0] sub;
    logic [3:0] low;
    logic is_jump, is_jump_ind, is_call, is_call_ind, is_sys, is_exit, is_exit_skip, is_exit_irq;
    logic is_unmask, is_mask, do_push, do_pop;
    logic [ctrl_flow_pkg::PC_W-1:0] next_pc;
    logic [ctrl_flow_pkg::SP_W-1:0] next_sp;

    assign op = instr[15:11];
    assign mid = instr[10:8];
    assign sub = instr[7:4];
    assign low = instr[3:0];
    assign is_jump = instr_valid && op >= ctrl_flow_pkg::OP_JUMP_P0 && op <= ctrl_flow_pkg::OP_JUMP_P3;
    assign is_call = instr_valid && op == ctrl_flow_pkg::OP_CALL;
    // Fixed forms need every unused field zero, else they are other opcodes
    function automatic logic fixed_form(input logic [15:0] word, input logic [2:0] m, input logic [3:0] s);
        return word[15:11] == ctrl_flow_pkg::OP_SYS && word[10:8] == m && word[7:4] == s && word[3:0] == 4'h0;
    endfunction
    assign is_jump_ind = instr_valid && fixed_form(instr, ctrl_flow_pkg::MID_PLAIN, ctrl_flow_pkg::SUB_JUMP_IND);
    assign is_call_ind = instr_valid && fixed_form(instr, ctrl_flow_pkg::MID_PLAIN, ctrl_flow_pkg::SUB_CALL_IND);
    assign is_sys = instr_valid && op == ctrl_flow_pkg::OP_SYS && sub == ctrl_flow_pkg::SUB_SYSCALL;
    assign is_exit = instr_valid && fixed_form(instr, ctrl_flow_pkg::MID_PLAIN, ctrl_flow_pkg::SUB_EXIT);
    assign is_exit_skip = instr_valid && fixed_form(instr, ctrl_flow_pkg::MID_SKIP, ctrl_flow_pkg::SUB_EXIT);
    assign is_exit_irq = instr_valid && fixed_form(instr, ctrl_flow_pkg::MID_IRQ, ctrl_flow_pkg::SUB_EXIT);
    assign is_unmask = instr_valid && fixed_form(instr, 3'h0, ctrl_flow_pkg::SUB_IRQ);
    assign is_mask = instr_valid && fixed_form(instr, 3'h1, ctrl_flow_pkg::SUB_IRQ);
    assign do_push = is_call || is_call_ind || is_sys;
    assign do_pop = is_exit || is_exit_skip || is_exit_irq;

    // ****************************************
    // Next program counter
    // ****************************************
    always_comb begin
        next_pc = pc;
        if (is_jump) begin
            next_pc = {1'b0, op[1:0], instr[10:0]}; // RL1
        end else if (is_jump_ind || is_call_ind) begin
            next_pc = address_register; // RL2
        end else if (is_call) begin
            next_pc = {pc[13:12], 1'b0, instr[10:0]}; // RL3
        end else if (is_sys) begin
            next_pc = {pc[13], 2'b00, mid, 4'h0, low}; // RL4
        end else if (do_pop) begin
            next_pc = stack_top; // RL5
        end
    end

    always_comb begin
        next_sp = sp;
        if (do_push) begin
            next_sp = sp - 3'h1; // RL2
        end else if (do_pop) begin
            next_sp = sp + 3'h1; // RL5
        end
    end

    // ****************************************
    // State
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc <= ctrl_flow_pkg::PC_RESET;
            sp <= ctrl_flow_pkg::SP_RESET;
        end else if (clk_en) begin
            pc <= next_pc;
            sp <= next_sp;
        end
    end

    // Push data is the pc before the transfer; stack logic stores it at the new sp
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            push_strobe <= 1'b0;
            push_data <= ctrl_flow_pkg::PC_RESET;
        end else if (clk_en) begin
            push_strobe <= do_push; // RL3
            push_data <= pc; // RL4
        end
    end

    // Skip is a pulse lasting one enabled cycle, telling fetch to discard the instruction at the new pc
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            skip_next <= 1'b0;
        end else if (clk_en) begin
            skip_next <= is_exit_skip; // RL6
        end
    end

    // Flag is sticky; cleared only by reset, since no clearing instruction is decoded here
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            system_call_flag <= 1'b0;
        end else if (clk_en && is_sys) begin
            system_call_flag <= 1'b1; // RL4
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            interrupt_context_reg <= ctrl_flow_pkg::CTX_RESET;
        end else if (clk_en && is_exit_irq) begin
            interrupt_context_reg <= interrupt_context_copy; // RL7
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            global_irq_gate <= 1'b0;
        end else if (clk_en) begin
            if (is_unmask) begin
                global_irq_gate <= 1'b1; // RL8
            end else if (is_mask) begin
                global_irq_gate <= 1'b0; // RL8
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Antecedents sample rst, so an attempt cannot start on the edge that releases reset
    jump_target_a: assert property (@(posedge sys_clk) disable iff (rst) // RL1
        !rst && clk_en && is_jump |=> pc == {1'b0, $past(instr[12:11]), $past(instr[10:0])})
        else $error("jump target wrong");
    ind_target_a: assert property (@(posedge sys_clk) disable iff (rst) // RL2
        !rst && clk_en && (is_jump_ind || is_call_ind) |=> pc == $past(address_register))
        else $error("indirect target wrong");
    call_push_a: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        !rst && clk_en && is_call |=> push_strobe && push_data == $past(pc) && sp == $past(sp) - 3'h1
        && pc[11] == 1'b0 && pc[10:0] == $past(instr[10:0]))
        else $error("call push wrong");
    sys_entry_a: assert property (@(posedge sys_clk) disable iff (rst) // RL4
        !rst && clk_en && is_sys |=> system_call_flag && push_strobe && pc[12:11] == 2'b00
        && pc[10:8] == $past(instr[10:8]) && pc[7:4] == 4'h0 && pc[3:0] == $past(instr[3:0]))
        else $error("system entry wrong");
    exit_pop_a: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        !rst && clk_en && do_pop |=> pc == $past(stack_top) && sp == $past(sp) + 3'h1 && !push_strobe)
        else $error("return pop wrong");
    // A stalled cycle legitimately keeps the skip pulse standing
    exit_skip_a: assert property (@(posedge sys_clk) disable iff (rst) // RL6
        !rst && clk_en && is_exit_skip |=> skip_next ##1 (!skip_next || !$past(clk_en) || $past(is_exit_skip)))
        else $error("skip pulse wrong");
    irq_restore_a: assert property (@(posedge sys_clk) disable iff (rst) // RL7
        !rst && clk_en && is_exit_irq |=> interrupt_context_reg == $past(interrupt_context_copy))
        else $error("context restore wrong");
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // RL8
        !rst && clk_en && (is_unmask || is_mask) |=> global_irq_gate == $past(is_unmask))
        else $error("interrupt gate wrong");

    // ****************************************
    // Hold and exclusivity checks
    // ****************************************
    // A stall must hold every output, pulses included, or stack logic would act twice
    freeze_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        !rst && !clk_en |=> $stable(pc) && $stable(sp) && $stable(push_strobe) && $stable(skip_next)
        && $stable(system_call_flag) && $stable(interrupt_context_reg) && $stable(global_irq_gate))
        else $error("frozen state moved");
    push_only_a: assert property (@(posedge sys_clk) disable iff (rst) // RL3
        !rst && clk_en && !do_push |=> !push_strobe)
        else $error("push strobe without push");
    ind_call_push_a: assert property (@(posedge sys_clk) disable iff (rst) // RL2
        !rst && clk_en && is_call_ind |=> push_strobe && push_data == $past(pc) && sp == $past(sp) - 3'h1)
        else $error("indirect call push wrong");
    jump_no_push_a: assert property (@(posedge sys_clk) disable iff (rst) // RL1
        !rst && clk_en && (is_jump || is_jump_ind) |=> !push_strobe && sp == $past(sp))
        else $error("jump touched stack");
    sys_push_a: assert property (@(posedge sys_clk) disable iff (rst) // RL4
        !rst && clk_en && is_sys |=> push_data == $past(pc) && sp == $past(sp) - 3'h1
        && pc[13] == $past(pc[13]))
        else $error("system call push wrong");
    flag_sticky_a: assert property (@(posedge sys_clk) disable iff (rst) // RL4
        !rst && system_call_flag |=> system_call_flag)
        else $error("system call flag dropped");
    skip_only_a: assert property (@(posedge sys_clk) disable iff (rst) // RL6
        !rst && clk_en && !is_exit_skip |=> !skip_next)
        else $error("skip pulse without skip return");
    exit_plain_a: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        !rst && clk_en && (is_exit || is_exit_irq) |=> !skip_next && !push_strobe)
        else $error("plain return raised a pulse");
    sp_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // RL5
        !rst && !(clk_en && (do_push || do_pop)) |=> sp == $past(sp))
        else $error("stack pointer moved without push or pop");
    // Refused encodings must leave pc where it is
    pc_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // RL1
        !rst && !(clk_en && (is_jump || is_jump_ind || is_call || is_call_ind || is_sys || do_pop))
        |=> pc == $past(pc))
        else $error("pc moved without a control-flow instruction");
    ctx_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // RL7
        !rst && !(clk_en && is_exit_irq) |=> interrupt_context_reg == $past(interrupt_context_reg))
        else $error("context changed outside interrupt return");
    gate_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // RL8
        !rst && !(clk_en && (is_unmask || is_mask)) |=> global_irq_gate == $past(global_irq_gate))
        else $error("interrupt gate changed without its instruction");
endmodule

// File: branch_call_return_decode_tb.sv
// Self-checking bench for the control-flow decode block
`timescale 1ns/100ps
module branch_call_return_decode_tb;
    logic sys_clk = 0, rst = 1, clk_en = 1, instr_valid = 0;
    logic [15:0] instr = 16'h0000;
    logic [13:0] address_register = 14'h0000, stack_top, pc, push_data, e_pc, e_pd;
    logic [3:0] interrupt_context_copy = 4'h0, interrupt_context_reg, e_ctx;
    logic [2:0] sp, e_sp;
    logic push_strobe, skip_next, system_call_flag, global_irq_gate, e_push, e_skip, e_flag, e_gate;
    logic [31:0] r;
    integer seed = 32'h80ab, mismatches = 0, total_checks = 0, cycles = 0;
    always #2 sys_clk = ~sys_clk;
    branch_call_return_decode i_branch_call_return_decode (.sys_clk, .rst, .clk_en, .instr_valid, .instr,
        .address_register, .stack_top, .interrupt_context_copy, .pc, .sp, .push_strobe, .push_data,
        .skip_next, .system_call_flag, .interrupt_context_reg, .global_irq_gate);
    ret_stack_model i_ret_stack_model (.sys_clk, .push_strobe, .push_data, .sp, .stack_top);
    // ************
    // Checking
    // ************
    task check(input string name, input logic [13:0] seen, input logic [13:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Nine calls wrap the 8-deep stack before the return forms
    function logic [15:0] pick(input int i, input logic [31:0] v);
        if (i < 16) return 16'he000 | 16'(i);
        case (i)
            16: return 16'h39e0;
            17: return 16'h3ae0;
            18: return 16'h38f0;
            19: return 16'h39f0;
            default: ;
        endcase
        case (v[31:28] % 12)
            0: return {3'b011, v[12:0]};
            1: return {5'h1c, v[10:0]};
            2: return {5'h07, v[10:8], 4'h2, v[3:0]};
            3: return 16'h3840;
            4: return 16'h3850;
            5: return 16'h38e0;
            6: return 16'h39e0;
            7: return 16'h3ae0;
            8: return 16'h38f0;
            9: return 16'h39f0;
            10: return {5'h07, v[10:8] | 3'h2, 4'hf, v[3:0]};
            default: return 16'h38e0 | 16'(v[3:0]);
        endcase
    endfunction
    task step;
        logic [4:0] op;
        logic [2:0] mid;
        logic [3:0] sub, low;
        logic [13:0] np;
        logic push;
        {op, mid, sub, low} = instr;
        np = e_pc;
        push = 0;
        if (rst) begin
            {e_pc, e_sp, e_push, e_pd, e_skip, e_flag, e_ctx, e_gate} = {14'h0, 3'h7, 15'h0, 1'b0, 1'b0, 4'h0, 1'b0};
        end else if (clk_en) begin
            e_push = 0;
            e_skip = 0;
            if (!instr_valid) ;
            else if (op[4:2] == 3'b011) np = {1'b0, op[1:0], instr[10:0]};
            else if (op == 5'h1c) begin
                push = 1;
                np = {e_pc[13:12], 1'b0, instr[10:0]};
            end else if (op == 5'h07 && sub == 4'h2) begin
                push = 1;
                e_flag = 1;
                np = {e_pc[13], 2'b00, mid, 4'h0, low};
            end else if (op == 5'h07 && low == 4'h0) begin
                if (mid == 0 && sub == 4'h4) np = address_register;
                if (mid == 0 && sub == 4'h5) {push, np} = {1'b1, address_register};
                if (mid < 3 && sub == 4'he) begin
                    {np, e_sp, e_skip} = {stack_top, e_sp + 3'h1, mid == 3'h1};
                    if (mid == 2) e_ctx = interrupt_context_copy;
                end
                if (mid < 2 && sub == 4'hf) e_gate = (mid == 0);
            end
            if (push) {e_sp, e_push, e_pd} = {e_sp - 3'h1, 1'b1, e_pc};
            e_pc = np;
        end
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            summarize;
        end
    end
    initial begin
        step();
        for (int i = 0; i < 2000; i++) begin
            @(posedge sys_clk);
            r = $random(seed);
            rst <= (i < 7) || (i == 1200);
            clk_en <= (i < 20) || (r[1:0] != 0);
            instr_valid <= (i < 20) || (r[4:2] != 0);
            instr <= pick(i, $random(seed));
            address_register <= r[31:18];
            interrupt_context_copy <= r[8:5];
            #1;
            check("pc", pc, e_pc);
            check("sp", 14'(sp), 14'(e_sp));
            check("push_strobe", 14'(push_strobe), 14'(e_push));
            if (e_push) check("push_data", push_data, e_pd);
            check("skip_next", 14'(skip_next), 14'(e_skip));
            check("sys_flag", 14'(system_call_flag), 14'(e_flag));
            check("ctx", 14'(interrupt_context_reg), 14'(e_ctx));
            check("gate", 14'(global_irq_gate), 14'(e_gate));
            step();
            if (i == 20) $display("test corner_sequence done");
        end
        $display("test random_mix done");
        summarize;
    end
endmodule

// File: ctrl_flow_pkg.sv
// Constants and encodings for the control-flow decode block
package ctrl_flow_pkg;
    localparam int PC_W = 14;
    localparam int SP_W = 3;
    localparam int CTX_W = 4;
    localparam logic [4:0] OP_JUMP_P0 = 5'h0c;
    localparam logic [4:0] OP_JUMP_P3 = 5'h0f;
    localparam logic [4:0] OP_CALL = 5'h1c;
    localparam logic [4:0] OP_SYS = 5'h07;
    localparam logic [3:0] SUB_JUMP_IND = 4'h4;
    localparam logic [3:0] SUB_CALL_IND = 4'h5;
    localparam logic [3:0] SUB_SYSCALL = 4'h2;
    localparam logic [3:0] SUB_EXIT = 4'he;
    localparam logic [3:0] SUB_IRQ = 4'hf;
    localparam logic [2:0] MID_PLAIN = 3'h0;
    localparam logic [2:0] MID_SKIP = 3'h1;
    localparam logic [2:0] MID_IRQ = 3'h2;
    localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
    localparam logic [SP_W-1:0] SP_RESET = 3'h7;
    localparam logic [CTX_W-1:0] CTX_RESET = 4'h0;
endpackage

// File: ret_stack_model.sv
// Return-address stack model standing beside the decode block
`timescale 1ns/100ps
module ret_stack_model (
    input wire logic sys_clk,
    input wire logic push_strobe,
    input wire logic [13:0] push_data,
    input wire logic [2:0] sp,
    output logic [13:0] stack_top
);
    logic [13:0] mem [8];
    initial begin
        for (int k = 0; k < 8; k++) begin
            mem[k] = 14'h0313 * 14'(k + 1);
        end
    end
    // Entry is written at the already decremented pointer
    always @(posedge sys_clk) begin
        if (push_strobe) begin
            mem[sp] <= push_data;
        end
    end
    // Forwarding lets a return follow a call back to back
    assign stack_top = push_strobe ? push_data : mem[sp];
endmodule
